// *** include/aip_pkg.sv ***
// Package for the auto-index phase sequencer.
// Assumes a 12-bit word, eight timing periods per phase, one clock per period.
package aip_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] AIP_CTRL_OFS = 8'h00;
	localparam logic [7:0] AIP_STAT_OFS = 8'h04;
	localparam logic [7:0] AIP_PC_OFS = 8'h08;
	localparam logic [7:0] AIP_AR_OFS = 8'h0c;
	localparam logic [7:0] AIP_MDR_OFS = 8'h10;
	localparam logic [7:0] AIP_IR_OFS = 8'h14;

	// Control register field positions.
	localparam int AIP_CTRL_RUN = 0;
	localparam int AIP_CTRL_TWO_WORD = 1;
	localparam int AIP_CTRL_FIELD_MEM = 2;
	localparam int AIP_CTRL_FIELD_LO = 4;

	// Reset values.
	localparam logic [11:0] AIP_PC_RESET = 12'h000;
	localparam logic [2:0] AIP_FIELD_RESET = 3'h0;

	// Instruction word layout; word bit 0, index 11 here, is the most significant bit.
	localparam int AIP_OP_HI = 11;
	localparam int AIP_OP_LO = 8;
	localparam int AIP_IND_BIT = 7;
	localparam int AIP_LAST_BIT = 6;
	localparam int AIP_REL_HI = 5;

	// Operate codes seen by this block.
	localparam logic [3:0] AIP_OP_MREF_LO = 4'h1;
	localparam logic [3:0] AIP_OP_MREF_HI = 4'ha;
	localparam logic [3:0] AIP_OP_INC = 4'h1;
	localparam logic [3:0] AIP_OP_DEC = 4'h2;
	localparam logic [3:0] AIP_OP_EXEC = 4'h8;
	localparam logic [3:0] AIP_OP_JUMP = 4'h9;

	// Fixed memory locations and the utility-gate constant.
	localparam logic [11:0] AIP_FIRST_LOC = 12'h000;
	localparam logic [11:0] AIP_UTIL_GATE = 12'hfff;

	// Period numbers inside a phase.
	localparam logic [2:0] AIP_P0 = 3'h0;
	localparam logic [2:0] AIP_P1 = 3'h1;
	localparam logic [2:0] AIP_P2 = 3'h2;
	localparam logic [2:0] AIP_P3 = 3'h3;
	localparam logic [2:0] AIP_P4 = 3'h4;
	localparam logic [2:0] AIP_P5 = 3'h5;
	localparam logic [2:0] AIP_P6 = 3'h6;
	localparam logic [2:0] AIP_P7 = 3'h7;

	// Phases of the sequencer.
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_PRIMARY,
		PH_SECONDARY,
		PH_EXEC
	} aip_phase_t;

endpackage

// *** rtl/aip_sequencer.sv ***
// Auto-index phase sequencer with an AXI4-Lite register slave.
// Assumes a core memory that answers a read in the same cycle as mem_rd.
// Summary of operation
// - Primary phase repeats the ordinary instruction fetch.
// - Period 3 starts auto-index on memory-reference opcodes.
// - Period 4 sets indirect and hold latches.
// - Location latch cleared early in period 5.
// - Location latch set on zero relative bits.
// - Auto-indexed jump routes 7777 into the adder when bit 5 set, else 0000.
// - Adder loads program counter for jumps and the execute-phase increment.
// - Pulse 7 enters secondary phase on indirect.
// - Secondary period 0 inhibits address and subtraction.
// - Pulse 0B routes 7777 when bit 5 set.
// - Secondary loads pointer location, reads pointer.
// - Period 4 adds data register to address side.
// - Carry-in increments pointer into address and data.
// - Pulse 5 writes incremented pointer back.
// - Clear location latch, then set execute phase.
// - Auto-indexed jump loads pointer into counter.
// - Execute period 0 reloads the address register.
// - Execute reads, writes back, sets done, returns.
// - Bit 5 picks first or last location.
// - Bit 4 selects indirect, needed for auto-index.
// - Operand processed per operate code bits.
// - Auto-indexed jump never enters execute phase.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module aip_sequencer
	import aip_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core memory word path.
	output logic [2:0] mem_field,
	output logic [11:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [11:0] mem_wdata,
	input wire logic [11:0] mem_rdata
);

	// Every register of the block lives in this one structure.
	typedef struct packed {
		aip_phase_t phase;
		logic [2:0] period;
		logic [11:0] pc;
		logic [11:0] address_reg;
		logic [11:0] memory_buffer_reg;
		logic [11:0] memory_data_reg;
		logic [11:0] instruction_reg;
		logic indirect_latch;
		logic indirect_hold_latch;
		logic first_last_location_latch;
		logic auto_init;
		logic done;
		logic run;
		logic two_word_flag;
		logic field_memory_latch;
		logic [2:0] field;
		logic [11:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [11:0] mem_wdata;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} aip_state_t;

	aip_state_t st_reg;
	aip_state_t st_next;

	// Decoded fields of the held instruction.
	logic [3:0] opcode;
	logic memref_decode;
	logic jump_op;
	logic xct_op;
	logic last_loc;
	logic rel_zero;
	logic [11:0] pointer_loc;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;
	// Instruction fields come straight from the instruction register.
	assign opcode = st_reg.instruction_reg[AIP_OP_HI:AIP_OP_LO];
	assign jump_op = (opcode == AIP_OP_JUMP);
	assign xct_op = (opcode == AIP_OP_EXEC);
	assign last_loc = st_reg.instruction_reg[AIP_LAST_BIT];
	assign rel_zero = (st_reg.instruction_reg[AIP_REL_HI:0] == 6'h00);
	assign memref_decode = (opcode >= AIP_OP_MREF_LO) &&
		(opcode <= AIP_OP_MREF_HI);
	assign pointer_loc = last_loc ? AIP_UTIL_GATE : AIP_FIRST_LOC;

	// Readable images of control and status.
	assign ctrl_word = {25'h0, st_reg.field, 1'b0,
		st_reg.field_memory_latch, st_reg.two_word_flag, st_reg.run};
	assign stat_word = {16'h0, 6'h0, st_reg.phase, st_reg.period,
		st_reg.done, st_reg.auto_init, st_reg.first_last_location_latch,
		st_reg.indirect_hold_latch, st_reg.indirect_latch};

	// Next-state logic for the sequencer and the bus slave.
	always_comb begin
		logic [11:0] adder;
		logic [11:0] wmask;
		adder = 12'h000;
		wmask = 12'h000;
		st_next = st_reg;
		st_next.mem_rd = 1'b0;
		st_next.mem_wr = 1'b0;
		// Sequencer runs one period per clock while enabled.
		if (st_reg.phase == PH_IDLE) begin
			// Leave idle at a phase boundary into a fresh fetch.
			if (st_reg.run) begin
				st_next.phase = PH_PRIMARY;
			end
		end else begin
			st_next.period = st_reg.period + 3'h1;
			unique case (st_reg.period)
				AIP_P0: begin
					// Period 0 forms an address in the adder.
					if (st_reg.phase == PH_PRIMARY) begin
						adder = st_reg.pc;
						st_next.instruction_reg = 12'h000;
					end else if (st_reg.phase == PH_SECONDARY) begin
						adder = {6'h00, st_reg.instruction_reg[AIP_REL_HI:0]};
						if (st_reg.first_last_location_latch && last_loc) begin
							adder = AIP_UTIL_GATE + adder;
						end
					end else begin
						adder = st_reg.address_reg +
							{6'h00, st_reg.instruction_reg[AIP_REL_HI:0]};
					end
					st_next.address_reg = adder;
				end
				AIP_P1: begin
					// Period 1 clears the buffer and starts the read.
					st_next.memory_buffer_reg = 12'h000;
					if (st_reg.phase == PH_PRIMARY) begin
						st_next.done = 1'b0;
					end
					if (st_reg.phase == PH_EXEC) begin
						adder = st_reg.pc + 12'h001;
						st_next.pc = adder;
					end
					st_next.mem_rd = 1'b1;
					st_next.mem_addr = st_reg.address_reg;
				end
				AIP_P2: begin
					st_next.memory_buffer_reg = mem_rdata;
				end
				AIP_P3: begin
					st_next.memory_data_reg = st_reg.memory_buffer_reg;
					if (st_reg.phase == PH_PRIMARY) begin
						st_next.instruction_reg = st_reg.memory_buffer_reg;
						st_next.auto_init = (st_reg.memory_buffer_reg
							[AIP_OP_HI:AIP_OP_LO] >= AIP_OP_MREF_LO) &&
							(st_reg.memory_buffer_reg[AIP_OP_HI:AIP_OP_LO] <=
							AIP_OP_MREF_HI);
					end else if (st_reg.phase == PH_SECONDARY) begin
						st_next.indirect_latch = 1'b0;
					end
				end
				AIP_P4: begin
					// Period 4 sets the indirect latches, or processes or increments the data word.
					if (st_reg.phase == PH_PRIMARY) begin
						if (memref_decode && !st_reg.indirect_hold_latch &&
							st_reg.instruction_reg[AIP_IND_BIT]) begin
							st_next.indirect_latch = 1'b1;
							st_next.indirect_hold_latch = 1'b1;
						end
					end else if (st_reg.phase == PH_SECONDARY) begin
						adder = st_reg.memory_data_reg + 12'h001;
						st_next.address_reg = adder;
						st_next.memory_data_reg = adder;
					end else begin
						if (opcode == AIP_OP_INC) begin
							st_next.memory_data_reg =
								st_reg.memory_data_reg + 12'h001;
						end else if (opcode == AIP_OP_DEC) begin
							st_next.memory_data_reg =
								st_reg.memory_data_reg - 12'h001;
						end
					end
					// The write of pulse 5 is staged here.
					st_next.mem_wr = 1'b1;
					st_next.mem_wdata = st_next.memory_data_reg;
					st_next.mem_addr = (st_reg.phase == PH_SECONDARY) ?
						pointer_loc : st_next.address_reg;
				end
				AIP_P5: begin
					st_next.first_last_location_latch = 1'b0;
					if (st_reg.phase == PH_PRIMARY && rel_zero &&
						memref_decode && !st_reg.two_word_flag &&
						!st_reg.field_memory_latch) begin
						st_next.first_last_location_latch = 1'b1;
					end
				end
				AIP_P6: begin
					// Period 6 handles the jump case and done.
					if (st_reg.phase == PH_PRIMARY && jump_op &&
						st_reg.first_last_location_latch) begin
						adder = last_loc ? AIP_UTIL_GATE : AIP_FIRST_LOC;
						st_next.pc = adder;
					end else if (st_reg.phase == PH_SECONDARY && jump_op) begin
						adder = st_reg.memory_data_reg;
						st_next.pc = adder;
					end else if (st_reg.phase == PH_EXEC) begin
						st_next.done = 1'b1;
					end
				end
				AIP_P7: begin
					// Pulse 7 chooses the following phase.
					if (st_reg.phase == PH_PRIMARY) begin
						if (st_reg.indirect_latch) begin
							st_next.phase = PH_SECONDARY;
						end else if (st_reg.two_word_flag || xct_op) begin
							st_next.phase = PH_PRIMARY;
						end else begin
							st_next.phase = PH_EXEC;
						end
					end else if (st_reg.phase == PH_SECONDARY) begin
						st_next.phase = jump_op ? PH_PRIMARY : PH_EXEC;
					end else begin
						st_next.phase = PH_PRIMARY;
					end
					// A fresh primary phase starts with its indirect, hold and auto-index latches clear.
					if (st_next.phase == PH_PRIMARY) begin
						st_next.indirect_latch = 1'b0;
						st_next.indirect_hold_latch = 1'b0;
						st_next.auto_init = 1'b0;
						if (!st_reg.run) begin
							st_next.phase = PH_IDLE;
						end
					end
				end
			endcase
		end
		// Write address channel is captured into a holding slot.
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		// Write data channel is captured independently.
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_full = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		// Response retires on bready.
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		// Both halves present and no response pending: perform the write.
		if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = 2'b00;
			wmask = {{4{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
			unique case (st_reg.aw_addr)
				AIP_CTRL_OFS: begin
					// Run, the two flags and the field number.
					if (st_reg.w_strb[0]) begin
						st_next.run = st_reg.w_data[AIP_CTRL_RUN];
						st_next.two_word_flag = st_reg.w_data[AIP_CTRL_TWO_WORD];
						st_next.field_memory_latch =
							st_reg.w_data[AIP_CTRL_FIELD_MEM];
						st_next.field =
							st_reg.w_data[AIP_CTRL_FIELD_LO +: 3];
					end
				end
				AIP_PC_OFS: begin
					// The counter may only be written while idle.
					if (st_reg.phase == PH_IDLE) begin
						st_next.pc = (st_reg.pc & ~wmask) |
							(st_reg.w_data[11:0] & wmask);
					end
				end
				// Read-only words ignore writes.
				AIP_STAT_OFS, AIP_AR_OFS, AIP_MDR_OFS, AIP_IR_OFS:
					st_next.bresp = 2'b00;
				default: begin
					st_next.bresp = 2'b10;
				end
			endcase
		end
		// Read data retires on rready; a new read is taken when none waits.
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = 2'b00;
			unique case (s_axi_araddr)
				AIP_CTRL_OFS: st_next.rdata = ctrl_word;
				AIP_STAT_OFS: st_next.rdata = stat_word;
				AIP_PC_OFS: st_next.rdata = {20'h0, st_reg.pc};
				AIP_AR_OFS: st_next.rdata = {20'h0, st_reg.address_reg};
				AIP_MDR_OFS: st_next.rdata = {20'h0, st_reg.memory_data_reg};
				AIP_IR_OFS: st_next.rdata = {20'h0, st_reg.instruction_reg};
				default: begin
					st_next.rdata = 32'h0;
					st_next.rresp = 2'b10;
				end
			endcase
		end
		// Ready outputs are registered from the settled next state.
		st_next.awready = !st_next.aw_full;
		st_next.wready = !st_next.w_full;
		st_next.arready = !st_next.rvalid;
	end

	// State register with synchronous reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.pc <= AIP_PC_RESET;
			st_reg.field <= AIP_FIELD_RESET;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
	// Outputs come straight from the state register.
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign mem_field = st_reg.field;
	assign mem_addr = st_reg.mem_addr;
	assign mem_rd = st_reg.mem_rd;
	assign mem_wr = st_reg.mem_wr;
	assign mem_wdata = st_reg.mem_wdata;

endmodule

// *** tb/aip_sequencer_properties.sv ***
// Checker for the sequencer's memory timing and register bus handshakes.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/10ps

module aip_seq_props (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core memory strobes.
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// The write of period 5 comes three periods after the read.
	sequence s_rd_to_wr;
		!mem_wr ##1 !mem_wr ##1 mem_wr;
	endsequence
	// No other read until period 2 of the next phase.
	sequence s_quiet_phase;
		!mem_rd [*7];
	endsequence
	property p_rd_pulse;
		mem_rd |=> s_quiet_phase;
	endproperty
	property p_rd_wr;
		mem_rd |=> s_rd_to_wr;
	endproperty
	property p_wr_cause;
		mem_wr |-> $past(mem_rd, 3);
	endproperty
	property p_wr_loc;
		mem_wr |-> mem_addr == $past(mem_addr, 3);
	endproperty
	property p_wr_gap;
		mem_wr |=> !mem_rd [*4];
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ar_excl;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read strobe repeated in a phase");
	a_rd_wr: assert property (p_rd_wr)
		else $error("write not at period 5");
	a_wr_cause: assert property (p_wr_cause)
		else $error("write without read");
	a_wr_loc: assert property (p_wr_loc)
		else $error("write back to another location");
	a_wr_gap: assert property (p_wr_gap)
		else $error("read too soon after write");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	a_ar_excl: assert property (p_ar_excl)
		else $error("read address ready wrong");
	a_r_answer: assert property (p_r_answer)
		else $error("read answer late");
	a_b_answer: assert property (p_b_answer)
		else $error("write answer timing wrong");
endmodule

bind aip_sequencer aip_seq_props u_aip_seq_props (.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr));

// *** tb/aip_core_mem.sv ***
// Behavioural core memory behind the sequencer's word path.
// Assumes reads are combinational while the read strobe is high.
`timescale 1ns/10ps

module aip_core_mem (
	// Clock.
	input wire logic clk,
	// Word path from the sequencer.
	input wire logic [2:0] mem_field,
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [11:0] mem_wdata,
	output logic [11:0] mem_rdata
);
	// Eight fields of 4096 words; the bench preloads words directly.
	logic [11:0] mem [0:32767];
	// Last word read, shown inverted while nothing is read.
	logic [11:0] last_reg = 12'h000;
	// Start from cleared memory so stray fetches see no unknowns.
	initial begin
		foreach (mem[i])
			mem[i] = 12'h000;
	end
	// Store writes and remember the last word read.
	always @(posedge clk) begin
		if (mem_wr)
			mem[{mem_field, mem_addr}] <= mem_wdata;
		if (mem_rd)
			last_reg <= mem_rdata;
	end
	// Data is valid only in the cycle of the read strobe.
	assign mem_rdata = mem_rd ? mem[{mem_field, mem_addr}] : ~last_reg;
endmodule

// *** tb/aip_sequencer_tb.sv ***
// Self-checking bench for the sequencer with a memory event model.
// Assumes the package, the design, the memory model and the checker.
`timescale 1ns/10ps

module aip_sequencer_tb
	import aip_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [2:0] fld = 3'h0;
	logic [31:0] rd_v;
	logic [1:0] rd_r;
	wire logic awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] mem_field;
	wire logic [11:0] mem_addr, mem_wdata, mem_rdata;
	int n_errors = 0;
	int checked = 0;
	// Program counter expected once a round has stopped.
	int exp_pc = 0;
	// Expected memory events: kind (1 write), address, data; model memory.
	int ev_k[$], ev_a[$], ev_d[$];
	int mm[int];

	always #12.5 clk = ~clk;

	aip_sequencer u_aip_sequencer (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .mem_field(mem_field), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));

	aip_core_mem u_aip_core_mem (.clk(clk), .mem_field(mem_field),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// Counts a comparison and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic give_verdict;
		if (n_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One register write; each channel drops when it is taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask

	// One register read; data is taken at the edge that shows rvalid.
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Loads a word into both the model memory and the partner.
	task automatic put(input int a, input int v);
		mm[a] = v;
		u_aip_core_mem.mem[{fld, a[11:0]}] = v[11:0];
	endtask

	// Queues one expected memory event.
	task automatic ev(input int k, input int a, input int d);
		ev_k.push_back(k);
		ev_a.push_back(a);
		ev_d.push_back(d & 'hfff);
	endtask

	// Builds eight auto-indexed instructions, the last a jump, and
	// predicts every read and write of the three phases.
	task automatic gen_round;
		int pc, ins, op, loc, ptr, i;
		int last;
		mm.delete();
		pc = 'h100;
		put(0, 'h7ff);
		put('hfff, 'h9ff);
		for (i = 0; i < 8; i++) begin
			op = (i == 7) ? AIP_OP_JUMP : $urandom_range(1, 2);
			last = $urandom_range(0, 1);
			ins = (op << 8) | 'h80 | (last << 6);
			loc = last ? 'hfff : 0;
			ptr = (mm[loc] + 1) & 'hfff;
			put(pc, ins);
			ev(0, pc, 0);
			ev(1, pc, ins);
			ev(0, loc, 0);
			ev(1, loc, ptr);
			mm[loc] = ptr;
			ev(0, ptr, 0);
			if (op != AIP_OP_JUMP) begin
				put(ptr, $urandom_range(2, 'hffd));
				ev(1, ptr, (op == AIP_OP_INC) ? mm[ptr] + 1 : mm[ptr] - 1);
				pc++;
			end else begin
				// The jump lands on a cleared word, which only bumps pc.
				put(ptr, 0);
				exp_pc = (ptr + 1) & 'hfff;
			end
		end
	endtask

	// Compares every memory access made while events are queued with the next expected event.
	always @(posedge clk) begin
		if (!rst && (mem_rd || mem_wr) && ev_k.size() > 0) begin
			chk("field", {29'h0, fld}, {29'h0, mem_field});
			chk("kind", ev_k[0], {31'h0, mem_wr});
			chk("addr", ev_a[0], {20'h0, mem_addr});
			if (mem_wr)
				chk("wdata", ev_d[0], {20'h0, mem_wdata});
			void'(ev_k.pop_front());
			void'(ev_a.pop_front());
			void'(ev_d.pop_front());
		end
	end

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict;
	end

	initial begin
		int t;
		void'($urandom(32'h3afe));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		axi_rd(AIP_CTRL_OFS, rd_v, rd_r);
		chk("ctrl", 32'h0, rd_v);
		axi_rd(AIP_PC_OFS, rd_v, rd_r);
		chk("pc", {20'h0, AIP_PC_RESET}, rd_v);
		axi_rd(8'h20, rd_v, rd_r);
		chk("unmapped data", 32'h0, rd_v);
		chk("unmapped resp", 32'h2, {30'h0, rd_r});
		axi_wr(8'h30, 32'h1, 2'b10);
		repeat (2) begin
			fld = 3'($urandom_range(0, 7));
			gen_round;
			axi_wr(AIP_PC_OFS, 32'h100, 2'b00);
			axi_wr(AIP_CTRL_OFS, {25'h0, fld, 4'h1}, 2'b00);
			t = 0;
			while (ev_k.size() > 0 && t < 3000) begin
				@(posedge clk);
				t++;
			end
			chk("events left", 32'h0, ev_k.size());
			axi_wr(AIP_CTRL_OFS, {25'h0, fld, 4'h0}, 2'b00);
			t = 0;
			do begin
				axi_rd(AIP_STAT_OFS, rd_v, rd_r);
				t++;
			end while (rd_v[9:8] !== 2'b00 && t < 50);
			chk("phase", 32'h0, {30'h0, rd_v[9:8]});
			axi_rd(AIP_PC_OFS, rd_v, rd_r);
			chk("pc after jump", exp_pc, rd_v);
		end
		give_verdict;
	end
endmodule
